/* rtl/bot_brake_timing.v */
// brake release output timing for a servo drive, wishbone slave
// assumes motor speed and status inputs are synchronous to clk_i
//
// The Wishbone register port and the placing of the registers are this design's own decisions.
`include "bot_defines.vh"

// How it works
// - alarm while running starts a stop, then brake output drops by speed or time
// - after power removal, brake applies once speed magnitude is below the level
// - after power removal, brake also applies when the wait time expires first
// - speed level settings take 0 to 10000, rotary default 100, linear 10
// - wait time takes 10 to 100 tens of ms, default 50, immediate
// - with zero-speed alarm stopping, off delay runs only once motor rests
// - speed reference is limited to maximum speed whatever the level setting
// - relay usage digit: 0 uses built-in relays, 1 not; applied on restart
// - second digit enables relay life alarm, reported as code 232h
// - stopping by dynamic brake, coasting, zero clamp or emergency decel
// - after stop: dynamic brake held or coasting; zero clamp holds position only in zero stop and off delay
// - alarms default to zero-speed stopping where that method applies
// - no dynamic brake variant coasts; otherwise power loss dynamic-brakes, but coasts during a zero-speed or decel stop
// - brake release output high releases brake; drops at servo off or alarm
// - during overtravel the brake release output stays high
module bot_brake_timing #(
	parameter TICK_CYCLES = `BOT_TICK_CYCLES,
	parameter HAS_DB      = 1
)(
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// wishbone slave
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [7:0]  adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output wire [31:0] dat_o,
	output wire        ack_o,
	// motor and power stage status
	input  wire [15:0] motor_speed_i,
	input  wire [15:0] max_speed_i,
	input  wire [15:0] speed_ref_i,
	input  wire        alarm_i,
	input  wire        zero_stop_ok_i,
	input  wire        main_power_ok_i,
	input  wire        ctrl_power_ok_i,
	input  wire        overtravel_i,
	input  wire        relay_worn_i,
	// brake and power stage drive
	output wire        brake_release_output,
	output wire        relay_drive_o,
	output wire        motor_power_o,
	output wire        dyn_brake_o,
	output wire        zero_clamp_o,
	output wire        decel_o,
	output wire [15:0] speed_ref_o,
	output wire        irq_o
);

	// sequencer states
	localparam ST_STOPPED = 3'h0;
	localparam ST_RUN     = 3'h1;
	localparam ST_ZSTOP   = 3'h2;
	localparam ST_BKDLY   = 3'h3;
	localparam ST_WAIT    = 3'h4;

	// magnitude of a two's complement value
	function [15:0] mag;
		input [15:0] v;
		begin
			mag = v[15] ? (~v + 16'h1) : v;
		end
	endfunction

	// limit a speed level to its setting range
	function [13:0] clamp_lvl;
		input [31:0] v;
		begin
			clamp_lvl = (v > {18'h0, `BOT_LVL_MAX}) ? `BOT_LVL_MAX : v[13:0];
		end
	endfunction

	reg  [31:0] ctrl_r;
	reg  [13:0] rot_lvl_r;
	reg  [13:0] lin_lvl_r;
	reg  [6:0]  wait_r;
	reg  [6:0]  bk_dly_r;
	reg  [1:0]  rly_pend_r;
	reg  [1:0]  rly_act_r;
	reg  [3:0]  irq_stat_r;
	reg  [3:0]  irq_mask_r;
	reg  [11:0] alarm_code_r;
	reg         ack_r;
	reg  [31:0] dat_r;
	reg  [2:0]  state_r;
	reg  [2:0]  state_nxt;
	reg         brake_r;
	reg         power_r;
	reg         db_r;
	reg         zc_r;
	reg         dec_r;
	reg  [15:0] sref_r;
	reg         alarm_d_r;
	reg         pwr_ok_d_r;
	reg         worn_d_r;
	reg         brake_d_r;
	reg         was_alarm_r;
	reg  [1:0]  method_r;
	reg  [31:0] wmask;
	reg  [31:0] wdat;
	reg  [31:0] rdat;
	reg  [3:0]  ev;

	wire        req;
	wire        wr;
	wire        srv_on;
	wire [15:0] spd;
	wire [15:0] lvl;
	wire        below_lvl;
	wire        at_rest;
	wire        pwr_ok;
	wire        stop_req;
	wire        tmr_start;
	wire [6:0]  tmr_units;
	wire        tmr_done;
	wire [15:0] ref_mag;
	wire [15:0] ref_lim;
	wire [31:0] ctrl_w;
	wire [1:0]  off_m;
	wire [1:0]  alm_m;

	assign req    = cyc_i & stb_i;
	assign wr     = req & we_i & ack_r;
	assign srv_on = ctrl_r[`BOT_CTRL_SRV_ON];
	assign off_m  = ctrl_r[`BOT_CTRL_OFF_HI:`BOT_CTRL_OFF_LO];
	assign alm_m  = ctrl_r[`BOT_CTRL_ALM_HI:`BOT_CTRL_ALM_LO];
	assign pwr_ok = main_power_ok_i & ctrl_power_ok_i;
	assign stop_req = ~srv_on | alarm_i | ~pwr_ok;

	// speed level by motor kind, magnitude compare
	assign spd = mag(motor_speed_i);
	assign lvl = ctrl_r[`BOT_CTRL_LINEAR] ? {2'h0, lin_lvl_r}
	                                      : {2'h0, rot_lvl_r};
	assign below_lvl = (spd < lvl);
	assign at_rest   = (spd < `BOT_REST_LVL);

	// byte enables into a write mask
	always @*
	begin
		wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
		wdat  = dat_i & wmask;
	end

	assign ctrl_w = (ctrl_r & ~wmask) | wdat;

	// register writes take effect on the acking edge
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_r     <= `BOT_CTRL_RST;
			rot_lvl_r  <= `BOT_ROT_LVL_RST;
			lin_lvl_r  <= `BOT_LIN_LVL_RST;
			wait_r     <= `BOT_WAIT_RST;
			bk_dly_r   <= `BOT_BK_DLY_RST;
			rly_pend_r <= 2'h0;
			rly_act_r  <= 2'h0;
			irq_mask_r <= 4'h0;
		end
		else if (wr)
		begin
			case (adr_i)
			`BOT_ADR_CTRL:    ctrl_r <= ctrl_w;
			`BOT_ADR_ROT_LVL: rot_lvl_r <= clamp_lvl(wdat);
			`BOT_ADR_LIN_LVL: lin_lvl_r <= clamp_lvl(wdat);
			`BOT_ADR_WAIT:
				// high bits first so large values clamp to max
				if (wdat[31:7] != 25'h0 || wdat[6:0] > `BOT_WAIT_MAX)
					wait_r <= `BOT_WAIT_MAX;
				else if (wdat[6:0] < `BOT_WAIT_MIN)
					wait_r <= `BOT_WAIT_MIN;
				else
					wait_r <= wdat[6:0];
			`BOT_ADR_BK_DLY:
				if (wdat[6:0] > `BOT_BK_DLY_MAX || wdat[31:7] != 25'h0)
					bk_dly_r <= `BOT_BK_DLY_MAX;
				else
					bk_dly_r <= wdat[6:0];
			`BOT_ADR_RELAY:
			begin
				rly_pend_r <= wdat[1:0];
				// soft restart copies in the relay digits written in the same cycle
				if (wdat[`BOT_RLY_APPLY])
					rly_act_r <= wdat[1:0];
			end
			`BOT_ADR_IRQ_MASK: irq_mask_r <= wdat[3:0];
			default: ;
			endcase
		end
	end

	// read mux
	always @*
	begin
		case (adr_i)
		`BOT_ADR_CTRL:     rdat = ctrl_r;
		`BOT_ADR_ROT_LVL:  rdat = {18'h0, rot_lvl_r};
		`BOT_ADR_LIN_LVL:  rdat = {18'h0, lin_lvl_r};
		`BOT_ADR_WAIT:     rdat = {25'h0, wait_r};
		`BOT_ADR_BK_DLY:   rdat = {25'h0, bk_dly_r};
		`BOT_ADR_RELAY:    rdat = {22'h0, rly_act_r, 6'h0, rly_pend_r};
		`BOT_ADR_STATUS:   rdat = {22'h0, was_alarm_r, power_r, dec_r, zc_r,
		                           db_r, brake_r, state_r, 1'b0};
		`BOT_ADR_IRQ_STAT: rdat = {28'h0, irq_stat_r};
		`BOT_ADR_IRQ_MASK: rdat = {28'h0, irq_mask_r};
		`BOT_ADR_ALARM:    rdat = {20'h0, alarm_code_r};
		default:           rdat = 32'h0;
		endcase
	end

	// one wait state, ack drops the cycle after it was given
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_r <= 1'b0;
			dat_r <= 32'h0;
		end
		else
		begin
			ack_r <= req & ~ack_r;
			dat_r <= rdat;
		end
	end

	assign ack_o = ack_r;
	assign dat_o = dat_r;

	// stopping method in force for the current stop
	always @(posedge clk_i)
	begin
		if (rst_i)
			method_r <= `BOT_STOP_DB;
		else if (state_r == ST_RUN && stop_req)
		begin
			if (~pwr_ok)
				method_r <= `BOT_STOP_DB;
			else if (alarm_i && zero_stop_ok_i)
				method_r <= alm_m;
			else if (alarm_i && alm_m[1])
				method_r <= off_m;
			else
				method_r <= alarm_i ? alm_m : off_m;
		end
	end

	// stop sequencer
	always @*
	begin
		state_nxt = state_r;
		case (state_r)
		ST_STOPPED:
			if (srv_on && !alarm_i && pwr_ok)
				state_nxt = ST_RUN;
		ST_RUN:
			if (stop_req)
			begin
				// zero-speed or decel stop keeps power until rest
				if (pwr_ok && alarm_i && zero_stop_ok_i && alm_m[1])
					state_nxt = ST_ZSTOP;
				else if (pwr_ok && at_rest)
					state_nxt = ST_BKDLY;
				else
					state_nxt = ST_WAIT;
			end
		ST_ZSTOP:
			if (~pwr_ok)
				state_nxt = ST_WAIT;
			else if (at_rest)
				state_nxt = ST_BKDLY;
		ST_BKDLY:
			if (tmr_done || ~pwr_ok)
				state_nxt = ST_STOPPED;
		ST_WAIT:
			if (below_lvl || tmr_done)
				state_nxt = ST_STOPPED;
		default:
			state_nxt = ST_STOPPED;
		endcase
	end

	// timer: off delay in bkdly, wait time from power removal
	assign tmr_start = (state_r != state_nxt) &&
	                   (state_nxt == ST_BKDLY || state_nxt == ST_WAIT);
	assign tmr_units = (state_nxt == ST_BKDLY) ? bk_dly_r : wait_r;

	bot_wait_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_timer (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.start_i (tmr_start),
		.stop_i  (state_r == ST_STOPPED),
		.units_i (tmr_units),
		.done_o  (tmr_done)
	);

	// speed reference limit to maximum speed
	assign ref_mag = mag(speed_ref_i);
	assign ref_lim = (ref_mag > max_speed_i) ?
	                 (speed_ref_i[15] ? (~max_speed_i + 16'h1) : max_speed_i)
	                 : speed_ref_i;

	// state, outputs and event detection
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_r     <= ST_STOPPED;
			brake_r     <= 1'b0;
			power_r     <= 1'b0;
			db_r        <= 1'b0;
			zc_r        <= 1'b0;
			dec_r       <= 1'b0;
			sref_r      <= 16'h0;
			alarm_d_r   <= 1'b0;
			pwr_ok_d_r  <= 1'b0;
			worn_d_r    <= 1'b0;
			brake_d_r   <= 1'b0;
			was_alarm_r <= 1'b0;
		end
		else
		begin
			state_r    <= state_nxt;
			alarm_d_r  <= alarm_i;
			pwr_ok_d_r <= pwr_ok;
			worn_d_r   <= relay_worn_i;
			brake_d_r  <= brake_release_output;
			if (state_r == ST_RUN && stop_req)
				was_alarm_r <= alarm_i;
			// release held in run, zero stop and wait, dropped in off delay and stopped
			brake_r <= (state_nxt == ST_RUN) ||
			           (state_nxt == ST_ZSTOP) ||
			           (state_nxt == ST_WAIT);
			power_r <= (state_nxt == ST_RUN) ||
			           (state_nxt == ST_ZSTOP) ||
			           (state_nxt == ST_BKDLY);
			// dynamic brake only on variants that carry one
			db_r  <= (HAS_DB != 0) && (state_nxt == ST_WAIT ||
			         state_nxt == ST_STOPPED) &&
			         (state_r != ST_STOPPED || db_r) &&
			         (method_r == `BOT_STOP_DB ||
			          (state_r == ST_RUN && ~pwr_ok));
			zc_r  <= (state_nxt == ST_ZSTOP || state_nxt == ST_BKDLY) &&
			         (method_r == `BOT_STOP_ZERO);
			dec_r <= (state_nxt == ST_ZSTOP) &&
			         (method_r == `BOT_STOP_DECEL);
			if (state_nxt == ST_RUN)
				sref_r <= ref_lim;
			else
				sref_r <= 16'h0;
		end
	end

	// events
	always @*
	begin
		ev = 4'h0;
		// falling edge of the release output
		ev[`BOT_EV_BRAKE]   = brake_d_r & ~brake_release_output;
		ev[`BOT_EV_ALARM]   = alarm_i & ~alarm_d_r;
		ev[`BOT_EV_PWR_LOSS] = pwr_ok_d_r & ~pwr_ok;
		ev[`BOT_EV_RELAY_LIFE] = relay_worn_i & ~worn_d_r &
		                       rly_act_r[`BOT_RLY_LIFE_EN];
	end

	// sticky status, write one to clear, set wins
	genvar gi;
	generate
		for (gi = 0; gi < `BOT_IRQ_BITS; gi = gi + 1)
		begin : g_irq
			always @(posedge clk_i)
			begin
				if (rst_i)
					irq_stat_r[gi] <= 1'b0;
				else if (ev[gi])
					irq_stat_r[gi] <= 1'b1;
				else if (wr && adr_i == `BOT_ADR_IRQ_STAT && wdat[gi])
					irq_stat_r[gi] <= 1'b0;
			end
		end
	endgenerate

	// relay life alarm code
	always @(posedge clk_i)
	begin
		if (rst_i)
			alarm_code_r <= 12'h0;
		else if (ev[`BOT_EV_RELAY_LIFE])
			alarm_code_r <= `BOT_ALM_RELAY_LIFE;
	end

	// outputs; overtravel keeps the brake released
	assign brake_release_output = brake_r | overtravel_i;
	assign relay_drive_o = brake_release_output &
	                       ~rly_act_r[`BOT_RLY_NOT_USED];
	assign motor_power_o = power_r;
	assign dyn_brake_o   = db_r;
	assign zero_clamp_o  = zc_r;
	assign decel_o       = dec_r;
	assign speed_ref_o   = sref_r;
	assign irq_o         = |(irq_stat_r & irq_mask_r);

endmodule // bot_brake_timing

/* rtl/bot_defines.vh */
// constants for the brake output timing block
// assumes a 125 MHz clock and a 32-bit classic wishbone register bus
`ifndef BOT_DEFINES_VH
`define BOT_DEFINES_VH

// clock and time units
`define BOT_CLK_KHZ        125000
`define BOT_TICK_MS        10
`define BOT_TICK_CYCLES    (`BOT_TICK_MS * `BOT_CLK_KHZ)

// register byte offsets
`define BOT_ADR_CTRL       8'h00
`define BOT_ADR_ROT_LVL    8'h04
`define BOT_ADR_LIN_LVL    8'h08
`define BOT_ADR_WAIT       8'h0C
`define BOT_ADR_BK_DLY     8'h10
`define BOT_ADR_RELAY      8'h14
`define BOT_ADR_STATUS     8'h18
`define BOT_ADR_IRQ_STAT   8'h1C
`define BOT_ADR_IRQ_MASK   8'h20
`define BOT_ADR_ALARM      8'h24

// ctrl fields
`define BOT_CTRL_SRV_ON    0
`define BOT_CTRL_LINEAR    1
`define BOT_CTRL_OFF_LO    2
`define BOT_CTRL_OFF_HI    3
`define BOT_CTRL_ALM_LO    4
`define BOT_CTRL_ALM_HI    5
`define BOT_CTRL_RST       32'h0000_0020

// relay selection fields
`define BOT_RLY_NOT_USED   0
`define BOT_RLY_LIFE_EN    1
`define BOT_RLY_APPLY      8

// stopping methods
`define BOT_STOP_DB        2'h0
`define BOT_STOP_COAST     2'h1
`define BOT_STOP_ZERO      2'h2
`define BOT_STOP_DECEL     2'h3

// setting limits and reset values
`define BOT_LVL_MAX        14'h2710
`define BOT_ROT_LVL_RST    14'h0064
`define BOT_LIN_LVL_RST    14'h000A
`define BOT_WAIT_MIN       7'h0A
`define BOT_WAIT_MAX       7'h64
`define BOT_WAIT_RST       7'h32
`define BOT_BK_DLY_MAX     7'h32
`define BOT_BK_DLY_RST     7'h00
`define BOT_REST_LVL       16'h0001

// events and alarm code
`define BOT_IRQ_BITS       4
`define BOT_EV_BRAKE       0
`define BOT_EV_ALARM       1
`define BOT_EV_PWR_LOSS    2
`define BOT_EV_RELAY_LIFE  3
`define BOT_ALM_RELAY_LIFE 12'h232

`endif

/* rtl/bot_wait_timer.v */
// counts a number of 10 ms ticks after a start pulse
// assumes start is a one-cycle pulse and units hold steady while running
`include "bot_defines.vh"

module bot_wait_timer #(
	parameter TICK_CYCLES = `BOT_TICK_CYCLES
)(
	// clock and reset
	input  wire       clk_i,
	input  wire       rst_i,
	// control
	input  wire       start_i,
	input  wire       stop_i,
	input  wire [6:0] units_i,
	// result
	output wire       done_o
);

	reg  [20:0] tick_r;
	reg  [6:0]  unit_r;
	reg         run_r;
	reg         done_r;

	// prescaler plus unit counter; zero units finish at once
	always @(posedge clk_i)
	begin
		if (rst_i || stop_i)
		begin
			tick_r <= 21'h0;
			unit_r <= 7'h0;
			run_r  <= 1'b0;
			done_r <= 1'b0;
		end
		else if (start_i)
		begin
			tick_r <= 21'h0;
			unit_r <= 7'h0;
			run_r  <= (units_i != 7'h0);
			done_r <= (units_i == 7'h0);
		end
		else if (run_r)
		begin
			if (tick_r == TICK_CYCLES[20:0] - 21'h1)
			begin
				tick_r <= 21'h0;
				unit_r <= unit_r + 7'h1;
				if (unit_r + 7'h1 >= units_i)
				begin
					run_r  <= 1'b0;
					done_r <= 1'b1;
				end
			end
			else
				tick_r <= tick_r + 21'h1;
		end
	end

	assign done_o = done_r;

endmodule // bot_wait_timer

/* tb/bot_brake_timing_checker.sv */
// port assertions for the brake output timing block
// assumes binding into every bot_brake_timing instance
module bot_chk #(
	parameter TICK_CYCLES = 4
)(
	// clock and reset
	input wire logic        clk_i,
	input wire logic        rst_i,
	// bus and motor side
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        ack_o,
	input wire logic        alarm_i,
	input wire logic        zero_stop_ok_i,
	input wire logic        overtravel_i,
	input wire logic [15:0] motor_speed_i,
	input wire logic [15:0] max_speed_i,
	input wire logic        brake_release_output,
	input wire logic        relay_drive_o,
	input wire logic        motor_power_o,
	input wire logic [15:0] speed_ref_o
);
	localparam int LIM = 100 * TICK_CYCLES + 4;
	logic [15:0] wait_cnt_r;
	// cycles unpowered with the brake still released
	always @(posedge clk_i)
	begin
		if (rst_i || motor_power_o || !brake_release_output || overtravel_i)
			wait_cnt_r <= 16'h0000;
		else
			wait_cnt_r <= wait_cnt_r + 16'h0001;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("request not acked next cycle");
	a_ot_hold: assert property (overtravel_i |-> brake_release_output)
		else $error("brake applied during overtravel");
	a_relay_gate: assert property (relay_drive_o |-> brake_release_output)
		else $error("relay driven with brake applied");
	a_ref_clamp: assert property ($signed(speed_ref_o) <=
		$signed({1'h0, max_speed_i}) &&
		$signed(speed_ref_o) >= -$signed({1'h0, max_speed_i}))
		else $error("speed reference above maximum");
	a_ref_idle: assert property (!motor_power_o |-> speed_ref_o == 16'h0000)
		else $error("reference while unpowered");
	a_alarm_cut: assert property (alarm_i && !zero_stop_ok_i &&
		motor_power_o && motor_speed_i != 16'h0000 |-> ##[1:3] !motor_power_o)
		else $error("alarm did not cut power");
	a_wait_limit: assert property (wait_cnt_r <= LIM)
		else $error("brake held past wait time");
endmodule // bot_chk

bind bot_brake_timing bot_chk #(.TICK_CYCLES(TICK_CYCLES)) i_bot_chk (
	.clk_i                (clk_i),
	.rst_i                (rst_i),
	.cyc_i                (cyc_i),
	.stb_i                (stb_i),
	.ack_o                (ack_o),
	.alarm_i              (alarm_i),
	.zero_stop_ok_i       (zero_stop_ok_i),
	.overtravel_i         (overtravel_i),
	.motor_speed_i        (motor_speed_i),
	.max_speed_i          (max_speed_i),
	.brake_release_output (brake_release_output),
	.relay_drive_o        (relay_drive_o),
	.motor_power_o        (motor_power_o),
	.speed_ref_o          (speed_ref_o)
);

/* tb/bot_motor_model.sv */
// behavioural motor and power stage at the far side of the block
// assumes speed follows the reference under power, else runs down
module bot_motor_model (
	// clock
	input  wire logic        clk_i,
	// drive from the block
	input  wire logic        power_i,
	input  wire logic [15:0] ref_i,
	input  wire logic [3:0]  decay_i,
	// measured speed
	output logic      [15:0] speed_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic signed [15:0] spd_r;
	logic signed [15:0] dec;
	assign speed_o = spd_r;
	assign dec = {12'h000, decay_i};
	initial spd_r = 16'h0000;
	// powered tracks the reference; unpowered loses decay_i a cycle
	always @(posedge clk_i)
	begin
		if (power_i)
			spd_r <= ref_i;
		else if (spd_r > dec)
			spd_r <= spd_r - dec;
		else if (spd_r < -dec)
			spd_r <= spd_r + dec;
		else
			spd_r <= 16'h0000;
	end
endmodule // bot_motor_model

/* tb/test_bot_brake_timing.sv */
// self-checking bench for the brake output timing block
// assumes a 10 ms tick shortened to 4 cycles and a behavioural motor
`include "bot_defines.vh"
module test_bot_brake_timing;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o;
	logic [7:0]  adr_i;
	logic [3:0]  sel_i, decay;
	logic [31:0] dat_i, dat_o, rdat;
	logic [15:0] motor_speed_i, max_speed_i, speed_ref_i, speed_ref_o;
	logic        alarm_i, zero_stop_ok_i, main_power_ok_i, ctrl_power_ok_i;
	logic        overtravel_i, relay_worn_i, brake_release_output;
	logic        relay_drive_o, motor_power_o, dyn_brake_o;
	logic        zero_clamp_o, decel_o;
	int          err_count, compares;

	// design and far-side motor
	bot_brake_timing #(
		.TICK_CYCLES (4)
	) i_bot_brake_timing (
		.clk_i                (clk_i),
		.rst_i                (rst_i),
		.cyc_i                (cyc_i),
		.stb_i                (stb_i),
		.we_i                 (we_i),
		.adr_i                (adr_i),
		.sel_i                (sel_i),
		.dat_i                (dat_i),
		.dat_o                (dat_o),
		.ack_o                (ack_o),
		.motor_speed_i        (motor_speed_i),
		.max_speed_i          (max_speed_i),
		.speed_ref_i          (speed_ref_i),
		.alarm_i              (alarm_i),
		.zero_stop_ok_i       (zero_stop_ok_i),
		.main_power_ok_i      (main_power_ok_i),
		.ctrl_power_ok_i      (ctrl_power_ok_i),
		.overtravel_i         (overtravel_i),
		.relay_worn_i         (relay_worn_i),
		.brake_release_output (brake_release_output),
		.relay_drive_o        (relay_drive_o),
		.motor_power_o        (motor_power_o),
		.dyn_brake_o          (dyn_brake_o),
		.zero_clamp_o         (zero_clamp_o),
		.decel_o              (decel_o),
		.speed_ref_o          (speed_ref_o),
		.irq_o                (irq_o)
	);
	bot_motor_model i_bot_motor_model (.clk_i(clk_i),
		.power_i(motor_power_o), .ref_i(speed_ref_o),
		.decay_i(decay), .speed_o(motor_speed_i));

	task complete_run;
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask

	// one classic cycle, held until ack is sampled high
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		n = 0;
		@(posedge clk_i);
		while (ack_o !== 1'h1 && n < 50)
		begin
			@(posedge clk_i);
			n++;
		end
		rdat = dat_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		chk("bus ack", 32'h1, {31'h0, n < 50});
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		wb(1'h0, a, 32'h0);
		chk(nm, e, rdat);
	endtask

	// cycles until brake (s=0) or power (s=1) is seen low
	task until_low(input int s, output int n);
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while ((s ? motor_power_o : brake_release_output) !== 1'h0 && n < 1500);
	endtask

	task run(input logic [31:0] c, input logic [15:0] r, input logic [3:0] k);
		int n;
		decay <= k;
		speed_ref_i <= r;
		wb(1'h1, `BOT_ADR_CTRL, c);
		n = 0;
		while (motor_power_o !== 1'h1 && n < 200)
		begin
			@(posedge clk_i);
			n++;
		end
		chk("run start", 32'h1, {31'h0, motor_power_o});
		repeat (4) @(posedge clk_i);
	endtask

	task t_regs;
		rd(`BOT_ADR_CTRL, 32'h20, "ctrl");
		rd(`BOT_ADR_ROT_LVL, 32'h64, "rot lvl");
		rd(`BOT_ADR_LIN_LVL, 32'hA, "lin lvl");
		rd(`BOT_ADR_WAIT, 32'h32, "wait");
		rd(`BOT_ADR_BK_DLY, 32'h0, "bk dly");
		wb(1'h1, 8'h28, 32'hFFFF_FFFF);
		rd(8'h28, 32'h0, "unmapped");
		wb(1'h1, `BOT_ADR_ROT_LVL, 32'h4E20);
		rd(`BOT_ADR_ROT_LVL, 32'h2710, "rot max");
		wb(1'h1, `BOT_ADR_WAIT, 32'h5);
		rd(`BOT_ADR_WAIT, 32'hA, "wait min");
		wb(1'h1, `BOT_ADR_WAIT, 32'hC8);
		rd(`BOT_ADR_WAIT, 32'h64, "wait max");
		wb(1'h1, `BOT_ADR_WAIT, 32'h80);
		rd(`BOT_ADR_WAIT, 32'h64, "wait wide");
		wb(1'h1, `BOT_ADR_ROT_LVL, 32'h64);
	endtask

	task t_speed;
		int n;
		logic signed [15:0] m;
		run(32'h21, 16'hFE0C, 4'h2);
		wb(1'h1, `BOT_ADR_CTRL, 32'h20);
		until_low(0, n);
		m = -$signed(motor_speed_i);
		chk("level stop", 32'h1, {31'h0, m < 100 && m > 90});
	endtask

	task t_wait;
		int n;
		wb(1'h1, `BOT_ADR_WAIT, 32'hA);
		run(32'h23, 16'h01F4, 4'h0);
		alarm_i <= 1'h1;
		zero_stop_ok_i <= 1'h0;
		until_low(1, n);
		chk("alarm cut", 32'h1, {31'h0, n < 5});
		until_low(0, n);
		chk("wait span", 32'h1, {31'h0, n > 36 && n < 42});
		wb(1'h1, `BOT_ADR_CTRL, 32'h20);
		alarm_i <= 1'h0;
	endtask

	task t_alarm;
		int n;
		wb(1'h1, `BOT_ADR_IRQ_STAT, 32'hF);
		wb(1'h1, `BOT_ADR_IRQ_MASK, 32'h2);
		wb(1'h1, `BOT_ADR_BK_DLY, 32'h5);
		run(32'h21, 16'h012C, 4'h3);
		zero_stop_ok_i <= 1'h1;
		alarm_i <= 1'h1;
		repeat (3) @(posedge clk_i);
		chk("zero clamp", 32'h3, {30'h0, zero_clamp_o, motor_power_o});
		until_low(0, n);
		until_low(1, n);
		chk("off delay", 32'h1, {31'h0, n > 17 && n < 23});
		chk("irq on", 32'h1, {31'h0, irq_o});
		rd(`BOT_ADR_IRQ_STAT, 32'h3, "irq stat");
		wb(1'h1, `BOT_ADR_IRQ_MASK, 32'h0);
		@(negedge clk_i);
		chk("irq masked", 32'h0, {31'h0, irq_o});
		wb(1'h1, `BOT_ADR_IRQ_STAT, 32'h3);
		rd(`BOT_ADR_IRQ_STAT, 32'h0, "irq clear");
		wb(1'h1, `BOT_ADR_CTRL, 32'h20);
		alarm_i <= 1'h0;
	endtask

	// emergency decel alarm stop keeps power until rest
	task t_decel;
		run(32'h31, 16'h012C, 4'h3);
		zero_stop_ok_i <= 1'h1;
		alarm_i <= 1'h1;
		repeat (3) @(posedge clk_i);
		chk("decel", 32'h5, {29'h0, decel_o, zero_clamp_o, motor_power_o});
		wb(1'h1, `BOT_ADR_CTRL, 32'h20);
		alarm_i <= 1'h0;
	endtask

	task t_relay;
		@(posedge clk_i);
		overtravel_i <= 1'h1;
		@(negedge clk_i);
		chk("overtravel", 32'h1, {31'h0, brake_release_output});
		@(posedge clk_i);
		overtravel_i <= 1'h0;
		wb(1'h1, `BOT_ADR_RELAY, 32'h3);
		rd(`BOT_ADR_RELAY, 32'h3, "pending");
		wb(1'h1, `BOT_ADR_RELAY, 32'h103);
		rd(`BOT_ADR_RELAY, 32'h303, "applied");
		run(32'h21, 16'h0064, 4'h1);
		chk("relay off", 32'h2, {30'h0, brake_release_output, relay_drive_o});
		wb(1'h1, `BOT_ADR_RELAY, 32'h102);
		@(negedge clk_i);
		chk("relay on", 32'h3, {30'h0, brake_release_output, relay_drive_o});
		@(posedge clk_i);
		relay_worn_i <= 1'h1;
		repeat (3) @(posedge clk_i);
		rd(`BOT_ADR_ALARM, 32'h232, "life code");
		relay_worn_i <= 1'h0;
		wb(1'h1, `BOT_ADR_CTRL, 32'h20);
	endtask

	task t_pwr;
		run(32'h21, 16'h7000, 4'h1);
		chk("ref clamp", 32'h800, {16'h0, speed_ref_o});
		main_power_ok_i <= 1'h0;
		repeat (4) @(posedge clk_i);
		chk("power loss", 32'h2, {30'h0, dyn_brake_o, motor_power_o});
		main_power_ok_i <= 1'h1;
		wb(1'h1, `BOT_ADR_CTRL, 32'h20);
	endtask

	// 125 MHz clock
	initial
	begin
		clk_i = 1'h0;
		forever #4 clk_i = ~clk_i;
	end

	// hang guard
	initial
	begin
		repeat (8000) @(posedge clk_i);
		err_count++;
		complete_run;
	end

	// reset, then the scenarios
	initial
	begin
		{cyc_i, stb_i, we_i, alarm_i, zero_stop_ok_i} = 5'h00;
		{overtravel_i, relay_worn_i} = 2'h0;
		{main_power_ok_i, ctrl_power_ok_i, rst_i} = 3'h7;
		adr_i = 8'h00;
		sel_i = 4'hF;
		dat_i = 32'h0;
		decay = 4'h1;
		max_speed_i = 16'h0800;
		speed_ref_i = 16'h0000;
		err_count = 0;
		compares = 0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'h0;
		t_regs;
		t_speed;
		t_wait;
		t_alarm;
		t_relay;
		t_pwr;
		t_decel;
		complete_run;
	end
endmodule // test_bot_brake_timing
